// ---- hw/rtc_trim_pkg.sv ----
// shared constants for the time-base source selection and rc trim link
// assumes one 100 MHz system clock on both ends
package rtc_trim_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS  = 10;
    localparam int unsigned REF_PERIOD_NS  = 30518;  // about 32.768 kHz
    localparam int unsigned REF_HALF_CYC   = REF_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int unsigned HALF_CNT_W     = 12;

    // ------------------------------------------------------------
    // trim protocol
    // ------------------------------------------------------------
    localparam logic [7:0]  TRIM_CMD_CODE  = 8'hA5;  // arbitrary direct command code
    localparam int unsigned CMD_BITS       = 8;
    localparam int unsigned REF_EDGES      = 65;
    localparam int unsigned EDGE_CNT_W     = 7;
    localparam int unsigned TRIM_W         = 18;
    localparam logic [TRIM_W-1:0] TRIM_RESET = 18'h00000;

endpackage : rtc_trim_pkg

// ---- hw/rtc_trim_if.sv ----
// link between host controller and receiver for the rc trim sequence
// assumes the testbench either joins both ends or drives the receiver end itself
`timescale 1ns/1ps
`default_nettype none

interface rtc_trim_if;
    logic cs;       // chip select, high during a sequence
    logic scl;      // serial clock, also carries the reference cycles
    logic serial_digital_interface;      // serial data from host

    modport host (output cs, output scl, output serial_digital_interface);
    modport device (input cs, input scl, input serial_digital_interface);
endinterface : rtc_trim_if

`default_nettype wire

// ---- hw/rtc_trim_device.sv ----
// receiver end: time-base source mux and rc oscillator trim capture
// assumes link pins are asynchronous to i_clk_sys and rc tick is a sys-clock pulse
//
// Functional notes
// - source bit 1 crystal, 0 rc oscillator
// - trim command starts rc calibration
// - host raises chip select, then sends command
// - host sends exactly 65 reference cycles
// - host lowers chip select afterwards
// - trim applied at 65th edge, volatile
// - trim lost on rc off or reset
// - external clock needs crystal oscillator enabled
// - external clock held high in power-down
// - time base about quarter of carrier
`timescale 1ns/1ps
`default_nettype none

module rtc_trim_device
    import rtc_trim_pkg::*;
(
    // clock and reset
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    // link
    rtc_trim_if.device             link,
    // configuration
    input  wire logic              i_time_base_source_select,
    input  wire logic              i_crystal_osc_enable,
    input  wire logic              i_rc_osc_on,
    // oscillator sources
    input  wire logic              i_crystal_input_pin,
    input  wire logic              i_rc_tick,
    // results
    output logic                   o_time_base_tick,
    output logic                   o_trim_busy,
    output logic                   o_trim_valid,
    output logic [TRIM_W-1:0]      o_trim_value
);

    // ------------------------------------------------------------
    // state type
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CMD  = 2'b01,
        ST_TRIM = 2'b10,
        ST_DONE = 2'b11
    } trim_state_e;

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic [1:0] cs_sync_reg;
    logic [1:0] scl_sync_reg;
    logic [1:0] sdi_sync_reg;
    logic [1:0] xin_sync_reg;
    logic       scl_prev_reg;
    logic       xin_prev_reg;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            cs_sync_reg  <= 2'h0;
            scl_sync_reg <= 2'h0;
            sdi_sync_reg <= 2'h0;
            xin_sync_reg <= 2'h0;
        end else begin
            cs_sync_reg  <= {cs_sync_reg[0], link.cs};
            scl_sync_reg <= {scl_sync_reg[0], link.scl};
            sdi_sync_reg <= {sdi_sync_reg[0], link.serial_digital_interface};
            xin_sync_reg <= {xin_sync_reg[0], i_crystal_input_pin};
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            scl_prev_reg <= 1'b0;
            xin_prev_reg <= 1'b0;
        end else begin
            scl_prev_reg <= scl_sync_reg[1];
            xin_prev_reg <= xin_sync_reg[1];
        end
    end

    logic cs_s;
    logic sdi_s;
    logic scl_rise;
    logic xin_rise;

    assign cs_s     = cs_sync_reg[1];
    assign sdi_s    = sdi_sync_reg[1];
    assign scl_rise = scl_sync_reg[1] & ~scl_prev_reg;
    assign xin_rise = xin_sync_reg[1] & ~xin_prev_reg;

    // ------------------------------------------------------------
    // time-base source selection
    // ------------------------------------------------------------
    // crystal path only ticks when its oscillator is enabled, which is also
    // how an external clock on the crystal input gets through
    logic tick_next;

    always_comb begin
        if (i_time_base_source_select) begin
            tick_next = xin_rise & i_crystal_osc_enable;
        end else begin
            tick_next = i_rc_tick & i_rc_osc_on;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_time_base_tick <= 1'b0;
        end else begin
            o_time_base_tick <= tick_next;
        end
    end

    // ------------------------------------------------------------
    // trim sequence state machine
    // ------------------------------------------------------------
    trim_state_e               state_reg;
    trim_state_e               state_next;
    logic [CMD_BITS-1:0]       cmd_shift_reg;
    logic [3:0]                cmd_cnt_reg;
    logic [EDGE_CNT_W-1:0]     edge_cnt_reg;
    logic [TRIM_W-1:0]         meas_reg;

    logic [CMD_BITS-1:0]       cmd_word;
    logic                      cmd_last;
    logic                      last_edge;

    assign cmd_word  = {cmd_shift_reg[CMD_BITS-2:0], sdi_s};
    assign cmd_last  = scl_rise && (cmd_cnt_reg == 4'(CMD_BITS - 1));
    assign last_edge = scl_rise && (edge_cnt_reg == EDGE_CNT_W'(REF_EDGES - 1));

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (cs_s) begin
                    state_next = ST_CMD;
                end
            end
            ST_CMD: begin
                if (!cs_s) begin
                    state_next = ST_IDLE;
                end else if (cmd_last) begin
                    // other commands are not ours; sit out the frame
                    state_next = (cmd_word == TRIM_CMD_CODE) ? ST_TRIM : ST_DONE;
                end
            end
            ST_TRIM: begin
                if (!cs_s) begin
                    state_next = ST_IDLE;
                end else if (last_edge) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: begin
                if (!cs_s) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // command shift register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || state_reg != ST_CMD) begin
            cmd_shift_reg <= 8'h00;
            cmd_cnt_reg   <= 4'h0;
        end else if (scl_rise) begin
            cmd_shift_reg <= cmd_word;
            cmd_cnt_reg   <= cmd_cnt_reg + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // reference edge count and period measurement
    // ------------------------------------------------------------
    // measures sys cycles between edge 1 and edge 65, i.e. 64 ref periods;
    // saturates so a stalled reference cannot wrap into a small value
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || state_reg != ST_TRIM) begin
            edge_cnt_reg <= 7'h00;
        end else if (scl_rise) begin
            edge_cnt_reg <= edge_cnt_reg + 7'h01;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || state_reg != ST_TRIM || edge_cnt_reg == 7'h00) begin
            meas_reg <= TRIM_RESET;
        end else if (meas_reg != {TRIM_W{1'b1}}) begin
            meas_reg <= meas_reg + 18'h00001;
        end
    end

    // ------------------------------------------------------------
    // volatile trim store
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || !i_rc_osc_on) begin
            o_trim_valid <= 1'b0;
            o_trim_value <= TRIM_RESET;
        end else if (state_reg == ST_TRIM && last_edge) begin
            o_trim_valid <= 1'b1;
            o_trim_value <= meas_reg;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_trim_busy <= 1'b0;
        end else begin
            o_trim_busy <= (state_next == ST_TRIM);
        end
    end

endmodule : rtc_trim_device

`default_nettype wire

// ---- hw/rtc_trim_host.sv ----
// host end: drives chip select, trim command and 65 reference cycles
// assumes the receiver samples the link with its own clock
`timescale 1ns/1ps
`default_nettype none

module rtc_trim_host
    import rtc_trim_pkg::*;
#(
    // half reference period in sys cycles; default gives the 32.768 kHz reference
    parameter int unsigned HALF_CYC = REF_HALF_CYC
)
(
    // clock and reset
    input  wire logic  i_clk_sys,
    input  wire logic  i_rst,
    // link
    rtc_trim_if.host   link,
    // user side
    input  wire logic  i_start,
    output logic       o_busy,
    output logic       o_done
);

    // ------------------------------------------------------------
    // state and divider
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        H_IDLE  = 3'b000,
        H_SETUP = 3'b001,
        H_CMD   = 3'b010,
        H_REF   = 3'b011,
        H_END   = 3'b100
    } host_state_e;

    host_state_e            state_reg;
    logic [HALF_CNT_W-1:0]  div_reg;
    logic                   half_tick;
    logic [3:0]             bit_cnt_reg;
    logic [EDGE_CNT_W-1:0]  ref_cnt_reg;
    logic [CMD_BITS-1:0]    cmd_reg;

    // one enable per half reference period paces every link change except the cs rise on i_start
    assign half_tick = (div_reg == HALF_CNT_W'(HALF_CYC - 1));

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || state_reg == H_IDLE || half_tick) begin
            div_reg <= 12'h000;
        end else begin
            div_reg <= div_reg + 12'h001;
        end
    end

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_reg   <= H_IDLE;
            link.cs     <= 1'b0;
            link.scl    <= 1'b0;
            link.serial_digital_interface    <= 1'b0;
            bit_cnt_reg <= 4'h0;
            ref_cnt_reg <= 7'h00;
            cmd_reg     <= 8'h00;
            o_done      <= 1'b0;
        end else begin
            o_done <= 1'b0;
            case (state_reg)
                H_IDLE: begin
                    if (i_start) begin
                        link.cs   <= 1'b1;
                        cmd_reg   <= TRIM_CMD_CODE;
                        state_reg <= H_SETUP;
                    end
                end
                H_SETUP: begin
                    if (half_tick) begin
                        link.serial_digital_interface    <= cmd_reg[CMD_BITS-1];
                        cmd_reg     <= {cmd_reg[CMD_BITS-2:0], 1'b0};
                        bit_cnt_reg <= 4'h0;
                        state_reg   <= H_CMD;
                    end
                end
                H_CMD: begin
                    if (half_tick) begin
                        link.scl <= ~link.scl;
                        if (link.scl) begin
                            if (bit_cnt_reg == 4'(CMD_BITS - 1)) begin
                                link.serial_digital_interface    <= 1'b0;
                                ref_cnt_reg <= 7'h00;
                                state_reg   <= H_REF;
                            end else begin
                                link.serial_digital_interface    <= cmd_reg[CMD_BITS-1];
                                cmd_reg     <= {cmd_reg[CMD_BITS-2:0], 1'b0};
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            end
                        end
                    end
                end
                H_REF: begin
                    if (half_tick) begin
                        link.scl <= ~link.scl;
                        if (!link.scl) begin
                            ref_cnt_reg <= ref_cnt_reg + 7'h01;
                        end else if (ref_cnt_reg == EDGE_CNT_W'(REF_EDGES)) begin
                            state_reg <= H_END;
                        end
                    end
                end
                H_END: begin
                    if (half_tick) begin
                        link.cs   <= 1'b0;
                        o_done    <= 1'b1;
                        state_reg <= H_IDLE;
                    end
                end
                default: begin
                    state_reg <= H_IDLE;
                end
            endcase
        end
    end

    assign o_busy = (state_reg != H_IDLE);

endmodule : rtc_trim_host

`default_nettype wire

// ---- sim/rtc_trim_props.sv ----
// link checks for the trim sequence between host end and receiver end
// assumes both ends share the system clock that samples the link
`timescale 1ns/1ps
`default_nettype none

module rtc_trim_props
    import rtc_trim_pkg::*;
#(
    // must match the host's half reference period
    parameter int unsigned HALF_CYC = REF_HALF_CYC
)
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // link
    input wire logic cs,
    input wire logic scl,
    input wire logic serial_digital_interface
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    // ----------------
    // frame trackers
    // ----------------
    logic [6:0]  rise_reg;
    logic [7:0]  cmd_reg;
    logic [11:0] gap_reg;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || !cs) begin
            rise_reg <= 7'h00;
        end else if ($rose(scl)) begin
            rise_reg <= rise_reg + 7'h01;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (cs && $rose(scl) && rise_reg < 7'h08) begin
            cmd_reg <= {cmd_reg[6:0], serial_digital_interface};
        end
    end

    // saturates so a long idle never wraps into a false match
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || $changed(scl)) begin
            gap_reg <= 12'h000;
        end else if (gap_reg != 12'hFFF) begin
            gap_reg <= gap_reg + 12'h001;
        end
    end

    // ----------------
    // properties
    // ----------------
    property p_scl_idle; !cs |-> !scl; endproperty
    property p_cs_first; $rose(cs) |-> !scl [*8]; endproperty
    property p_sdi_hold; scl && $past(scl) |-> $stable(serial_digital_interface); endproperty
    property p_cmd_code; cs && rise_reg == 7'h09 |-> cmd_reg == TRIM_CMD_CODE; endproperty
    property p_ref_sdi; cs && rise_reg > 7'h08 |-> !serial_digital_interface; endproperty
    property p_half; $changed(scl) && rise_reg != 7'h00 |-> gap_reg == HALF_CYC - 1; endproperty
    property p_count; $fell(cs) |-> rise_reg == 7'h49; endproperty
    property p_cs_end; $fell(cs) |-> !scl && gap_reg == HALF_CYC - 1; endproperty

    a_scl_idle: assert property (p_scl_idle) else $error("scl moved outside a frame");
    a_cs_first: assert property (p_cs_first) else $error("scl moved right after cs");
    a_sdi_hold: assert property (p_sdi_hold) else $error("sdi changed while scl high");
    a_cmd_code: assert property (p_cmd_code) else $error("wrong command on the link");
    a_ref_sdi: assert property (p_ref_sdi) else $error("sdi active in reference phase");
    a_half: assert property (p_half) else $error("scl half period wrong");
    a_count: assert property (p_count) else $error("wrong scl rise count in frame");
    a_cs_end: assert property (p_cs_end) else $error("cs dropped at wrong time");

    c_frame_start: cover property ($rose(cs));
    c_command: cover property (cs && rise_reg == 7'h09);
    c_frame_end: cover property ($fell(cs) && rise_reg == 7'h49);
endmodule // rtc_trim_props

`default_nettype wire

// ---- sim/rtc_source_and_rc_trim_tb.sv ----
// bench: host end drives one receiver, the bench itself drives a second one
// assumes package timing constants and a 100 MHz system clock
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; \
    $display("CHECK FAILED at %0t: got %0h expected %0h", $time, (a), (e)); end end

module rtc_source_and_rc_trim_tb
    import rtc_trim_pkg::*;
;
    localparam int HALF = 8;  // 160 ns bench link clock
    // host divider shortened so a full frame fits the run budget
    localparam int HOST_HALF = 10;

    logic              clk, rst, start, busy, done, sel, xen, rc_on, crystal_input_pin, rc_tick;
    logic              tick1, valid1, valid2, cs_q, scl_q, tbusy1;
    logic [TRIM_W-1:0] value1, value2;
    int                errors, total_checks, ticks, rises;

    rtc_trim_if link1 ();
    rtc_trim_if link2 ();

    rtc_trim_host #(.HALF_CYC(HOST_HALF)) rtc_trim_host_i (.i_clk_sys(clk), .i_rst(rst),
        .link(link1),
        .i_start(start), .o_busy(busy), .o_done(done));
    rtc_trim_device rtc_trim_device_i (.i_clk_sys(clk), .i_rst(rst), .link(link1),
        .i_time_base_source_select(sel), .i_crystal_osc_enable(xen), .i_rc_osc_on(rc_on),
        .i_crystal_input_pin(crystal_input_pin), .i_rc_tick(rc_tick), .o_time_base_tick(tick1),
        .o_trim_busy(tbusy1), .o_trim_valid(valid1), .o_trim_value(value1));
    rtc_trim_device rtc_trim_device_2_i (.i_clk_sys(clk), .i_rst(rst), .link(link2),
        .i_time_base_source_select(sel), .i_crystal_osc_enable(xen), .i_rc_osc_on(rc_on),
        .i_crystal_input_pin(crystal_input_pin), .i_rc_tick(rc_tick), .o_time_base_tick(),
        .o_trim_busy(), .o_trim_valid(valid2), .o_trim_value(value2));
    rtc_trim_props #(.HALF_CYC(HOST_HALF)) rtc_trim_props_i (.i_clk_sys(clk), .i_rst(rst),
        .cs(link1.cs),
        .scl(link1.scl), .serial_digital_interface(link1.serial_digital_interface));

    // ----------------
    // clock and monitors
    // ----------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cs_q <= link1.cs;
        scl_q <= link1.scl;
        if (link1.cs && !cs_q) rises <= 0;
        else if (link1.cs && link1.scl && !scl_q) rises <= rises + 1;
        if (tick1 === 1'b1) ticks <= ticks + 1;
    end

    // ----------------
    // tasks
    // ----------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic report_and_stop();
        if (errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic sources(input logic s, input logic en, input int exp);
        sel = s;
        xen = en;
        step(8);
        ticks = 0;
        for (int i = 0; i < 5; i++) begin
            rc_tick = 1'b1;
            crystal_input_pin = (i < 3);
            step(1);
            rc_tick = 1'b0;
            step(9);
            crystal_input_pin = 1'b0;
            step(10);
        end
        `CHK(ticks, exp)
    endtask

    // external clock parked high must not produce ticks
    task automatic held_high();
        sel = 1'b1;
        xen = 1'b1;
        crystal_input_pin = 1'b1;
        step(8);
        ticks = 0;
        step(100);
        `CHK(ticks, 0)
        crystal_input_pin = 1'b0;
        step(8);
    endtask

    task automatic pulse_scl();
        step(HALF);
        link2.scl = 1'b1;
        step(HALF);
        link2.scl = 1'b0;
    endtask

    task automatic send_frame(input logic [7:0] cmd, input int edges);
        link2.cs = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            step(HALF);
            link2.serial_digital_interface = cmd[i];
            pulse_scl();
        end
        link2.serial_digital_interface = 1'b0;
        for (int i = 0; i < edges; i++) pulse_scl();
        step(HALF);
        link2.cs = 1'b0;
        step(HALF);
    endtask

    // measured count stops one cycle before edge 65 is seen
    task automatic host_trim();
        int   n;
        logic seen;
        n = 0;
        seen = 1'b0;
        start = 1'b1;
        step(1);
        start = 1'b0;
        step(1);
        `CHK(busy, 1'b1)
        while (done !== 1'b1 && n < 5000) begin
            step(1);
            if (tbusy1 === 1'b1) seen = 1'b1;
            n++;
        end
        `CHK(done, 1'b1)
        `CHK(seen, 1'b1)
        `CHK(tbusy1, 1'b0)
        `CHK(rises, 73)
        `CHK(valid1, 1'b1)
        `CHK(value1, TRIM_W'(128 * HOST_HALF - 1))
        step(2);
        `CHK(busy, 1'b0)
    endtask

    // wrong code, capture, abort, clear, surplus edges, reset
    task automatic device_link();
        send_frame(~TRIM_CMD_CODE, 65);
        `CHK(valid2, 1'b0)
        send_frame(TRIM_CMD_CODE, 65);
        `CHK(valid2, 1'b1)
        `CHK(value2, TRIM_W'(128 * HALF - 1))
        send_frame(TRIM_CMD_CODE, 30);
        `CHK(value2, TRIM_W'(128 * HALF - 1))
        rc_on = 1'b0;
        step(2);
        `CHK(valid2, 1'b0)
        `CHK(value1, TRIM_RESET)
        rc_on = 1'b1;
        send_frame(TRIM_CMD_CODE, 70);
        `CHK(value2, TRIM_W'(128 * HALF - 1))
        rst = 1'b1;
        step(2);
        rst = 1'b0;
        step(1);
        `CHK(valid2, 1'b0)
        `CHK(value2, TRIM_RESET)
    endtask

    // ----------------
    // main sequence
    // ----------------
    initial begin
        errors = 0;
        total_checks = 0;
        ticks = 0;
        rises = 0;
        rst = 1'b1;
        start = 1'b0;
        sel = 1'b0;
        xen = 1'b1;
        rc_on = 1'b1;
        crystal_input_pin = 1'b0;
        rc_tick = 1'b0;
        link2.cs = 1'b0;
        link2.scl = 1'b0;
        link2.serial_digital_interface = 1'b0;
        step(12);
        rst = 1'b0;
        step(2);
        sources(1'b0, 1'b1, 5);
        sources(1'b1, 1'b1, 3);
        sources(1'b1, 1'b0, 0);
        held_high();
        host_trim();
        device_link();
        report_and_stop();
    end

    // whole run needs under 10k cycles; 30k cycles means a hang
    initial begin
        #300000;
        errors++;
        report_and_stop();
    end
endmodule // rtc_source_and_rc_trim_tb

`default_nettype wire
